// >>> src/adc_pkg.sv
package adc_pkg;
    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int SMP_W         = 12;
    localparam int SPI_TOTAL     = 24;
    localparam int SPI_ADDR_LAST = 7;
    localparam int SPI_DATA_FIRST = 9;
    localparam int ACC_W         = 20;
    localparam int ACC_SHIFT     = 8;
    localparam int FIFO_DEPTH    = 16;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [6:0] ADDR_CFG   = 7'h00;
    localparam logic [6:0] ADDR_CORR  = 7'h01;
    localparam logic [6:0] ADDR_THR   = 7'h02;
    localparam logic [6:0] ADDR_RSTA  = 7'h03;
    localparam logic [6:0] ADDR_RSTB  = 7'h1A;
    localparam logic [6:0] ADDR_STAT  = 7'h70;

    localparam int CFG_WIRE4_BIT = 15;
    localparam int CFG_DECIM_BIT = 14;
    localparam int CFG_HPA_BIT   = 12;
    localparam int CFG_HPB_BIT   = 9;
    localparam int CORR_A_BIT    = 15;
    localparam int CORR_B_BIT    = 9;
    localparam int CORR_FMT_BIT  = 3;
    localparam int THR_LSB       = 7;
    localparam int THR_W         = 4;
    localparam int RESTART_BIT   = 14;
    localparam int THR_SCALE_SH  = 7;

    localparam logic [15:0]      CFG_MASK   = 16'hD240;
    localparam logic [15:0]      CORR_MASK  = 16'h820A;
    localparam logic [15:0]      CFG_RST    = 16'h0000;
    localparam logic [15:0]      CORR_RST   = 16'h0000;
    localparam logic [THR_W-1:0] THR_RST    = 4'hF;
    localparam logic [15:0]      RST_FIXED  = 16'h0B18;

    // ****************************************************************
    // timing in sample clock cycles
    // ****************************************************************
    localparam int             OVR_LATENCY   = 12;
    localparam int             SYNC_CNT_W    = 5;
    localparam logic [5:0]     INVALID_FULL  = 6'h24;
    localparam logic [5:0]     INVALID_DECIM = 6'h12;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        SPI_IDLE = 2'b00,
        SPI_ADDR = 2'b01,
        SPI_DATA = 2'b11
    } adc_spi_state_t;

    typedef struct packed {
        logic             marker;
        logic             valid;
        logic [1:0]       overRange;
        logic [SMP_W-1:0] dataA;
        logic [SMP_W-1:0] dataB;
    } adc_word_t;
endpackage

// >>> src/adc_ctrl_top.sv
// Behaviour
// - over-range flag appears 12 sample cycles later
// - trip level is full scale times field/16
// - threshold field resets to fifteen
// - correction off until enable bits set
// - channel restart controls at 0x03, 0x1A
// - decimated: per-channel filter selectable low or high pass
// - first sync resets logic, starts 32-cycle marker
// - data invalid 36 samples after sync
// - marker on next output rise; restarts on shift
// - sync single or every 32, sampled rising
// - falling-phase alignment stretches output clock half
// - decimated: period 32, discard 18 samples
// - starts 3-pin, one write enables 4-pin
// - read/write bit and seven address bits, then sixteen data bits
// - first serial rise latches read/write bit
// - write: zero, address, data, rising edges
// - read: D15..D0 shifted out for rising capture
// - read bit blocks writes until cleared
// - reset pin returns everything to defaults
// - restart bit clears accumulators, clear starts loop
// - address 0 bit 14 enables decimation
// - address 0 bit 15 selects four-wire
`timescale 1ns/1ps

module adc_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    // fill side
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    // drain side
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wrPtr_reg;
    logic [AW:0]  rdPtr_reg;

    assign inReady  = (wrPtr_reg - rdPtr_reg) != (AW+1)'(DEPTH);
    assign outValid = wrPtr_reg != rdPtr_reg;
    assign outData  = mem[rdPtr_reg[AW-1:0]];

    always_ff @(posedge clk_sys) begin
        if (inValid && inReady) begin
            mem[wrPtr_reg[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end else begin
            if (inValid && inReady) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (outValid && outReady) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
        end
    end
endmodule

module adc_ctrl_top
    import adc_pkg::*;
(
    // system clock and hardware reset pin
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    // serial configuration port
    input  wire logic             serialClk,
    input  wire logic             serialSelectN,
    input  wire logic             serDataIn,
    output logic                  serDataOut,
    output logic                  serDataOe,
    output logic                  serialOutputLine,
    // sample side
    input  wire logic             sampleClockIn,
    input  wire logic [SMP_W-1:0] sampleA,
    input  wire logic [SMP_W-1:0] sampleB,
    input  wire logic             alignInputPin,
    // output side
    output logic                  channelAOutputClock,
    output logic                  channelBOutputClock,
    output logic [1:0]            overRangeFlagOut,
    output logic                  alignMarkerOut,
    output logic                  pathReady,
    output logic                  outValid,
    input  wire logic             outReady,
    output adc_word_t             outData
);
    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    logic [1:0]       sclkS_reg, selS_reg, sdiS_reg, clkS_reg, syncS_reg;
    logic [SMP_W-1:0] smpA1_reg, smpA2_reg, smpB1_reg, smpB2_reg;
    logic             sclkPrev_reg, selPrev_reg, clkPrev_reg;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sclkS_reg    <= '0;
            selS_reg     <= 2'h3;
            sdiS_reg     <= '0;
            clkS_reg     <= '0;
            syncS_reg    <= '0;
            smpA1_reg    <= '0;
            smpA2_reg    <= '0;
            smpB1_reg    <= '0;
            smpB2_reg    <= '0;
            sclkPrev_reg <= 1'b0;
            selPrev_reg  <= 1'b1;
            clkPrev_reg  <= 1'b0;
        end else begin
            sclkS_reg    <= {sclkS_reg[0], serialClk};
            selS_reg     <= {selS_reg[0], serialSelectN};
            sdiS_reg     <= {sdiS_reg[0], serDataIn};
            clkS_reg     <= {clkS_reg[0], sampleClockIn};
            syncS_reg    <= {syncS_reg[0], alignInputPin};
            smpA1_reg    <= sampleA;
            smpA2_reg    <= smpA1_reg;
            smpB1_reg    <= sampleB;
            smpB2_reg    <= smpB1_reg;
            sclkPrev_reg <= sclkS_reg[1];
            selPrev_reg  <= selS_reg[1];
            clkPrev_reg  <= clkS_reg[1];
        end
    end

    logic sRise, sFall, selFall, sTick;
    assign sRise   = sclkS_reg[1] && !sclkPrev_reg;
    assign sFall   = !sclkS_reg[1] && sclkPrev_reg;
    assign selFall = !selS_reg[1] && selPrev_reg;
    assign sTick   = clkS_reg[1] && !clkPrev_reg;

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    logic [15:0]      cfg_reg, corr_reg;
    logic [THR_W-1:0] thr_reg;
    logic [1:0]       restart_reg;
    logic             wrEn;
    logic [6:0]       wrAddr;
    logic [15:0]      wrData;
    logic             running_reg;
    logic [5:0]       invalidCnt_reg;
    logic             writeBlock_reg;

    logic wire4, decimEn, offsetBin;
    logic [1:0] highPass, corrEn;
    assign wire4     = cfg_reg[CFG_WIRE4_BIT];
    assign decimEn   = cfg_reg[CFG_DECIM_BIT];
    assign highPass  = {cfg_reg[CFG_HPB_BIT], cfg_reg[CFG_HPA_BIT]};
    assign corrEn    = {corr_reg[CORR_B_BIT], corr_reg[CORR_A_BIT]};
    assign offsetBin = corr_reg[CORR_FMT_BIT];

    // reset pin returns the whole map to its defaults, shortest legal pulse included
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cfg_reg     <= CFG_RST;
            corr_reg    <= CORR_RST;
            thr_reg     <= THR_RST;
            restart_reg <= '0;
        end else if (wrEn) begin
            case (wrAddr)
                ADDR_CFG:  cfg_reg  <= wrData & CFG_MASK;
                ADDR_CORR: corr_reg <= wrData & CORR_MASK;
                ADDR_THR:  thr_reg  <= wrData[THR_LSB +: THR_W];
                ADDR_RSTA: restart_reg[0] <= wrData[RESTART_BIT];
                ADDR_RSTB: restart_reg[1] <= wrData[RESTART_BIT];
                default:   ;
            endcase
        end
    end

    function automatic logic [15:0] regRead(input logic [6:0] a);
        logic [15:0] r;
        r = 16'h0000;
        case (a)
            ADDR_CFG:  r = cfg_reg;
            ADDR_CORR: r = corr_reg;
            ADDR_THR:  r[THR_LSB +: THR_W] = thr_reg;
            ADDR_RSTA: r = RST_FIXED | (16'(restart_reg[0]) << RESTART_BIT);
            ADDR_RSTB: r = RST_FIXED | (16'(restart_reg[1]) << RESTART_BIT);
            ADDR_STAT: r = {running_reg, writeBlock_reg, pathReady, 7'h00, invalidCnt_reg};
            default:   r = 16'h0000;
        endcase
        return r;
    endfunction

    // ****************************************************************
    // serial port
    // ****************************************************************
    adc_spi_state_t spiState_reg;
    logic [4:0]     bitCnt_reg;
    logic [22:0]    shiftIn_reg;
    logic [15:0]    shiftOut_reg;
    logic           rw_reg;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            spiState_reg   <= SPI_IDLE;
            bitCnt_reg     <= '0;
            shiftIn_reg    <= '0;
            shiftOut_reg   <= '0;
            rw_reg         <= 1'b0;
            writeBlock_reg <= 1'b0;
        end else if (selS_reg[1]) begin
            spiState_reg <= SPI_IDLE;
        end else if (selFall) begin
            spiState_reg <= SPI_ADDR;
            bitCnt_reg   <= '0;
        end else if (spiState_reg != SPI_IDLE) begin
            if (sRise) begin
                shiftIn_reg <= {shiftIn_reg[21:0], sdiS_reg[1]};
                bitCnt_reg  <= bitCnt_reg + 1'b1;
                if (bitCnt_reg == '0) begin
                    rw_reg         <= sdiS_reg[1];
                    writeBlock_reg <= sdiS_reg[1];
                end
                if (bitCnt_reg == 5'(SPI_ADDR_LAST)) begin
                    spiState_reg <= SPI_DATA;
                    shiftOut_reg <= regRead({shiftIn_reg[5:0], sdiS_reg[1]});
                end
                if (bitCnt_reg == 5'(SPI_TOTAL - 1)) begin
                    spiState_reg <= SPI_IDLE;
                end
            end else if (sFall && spiState_reg == SPI_DATA
                         && bitCnt_reg >= 5'(SPI_DATA_FIRST)) begin
                shiftOut_reg <= {shiftOut_reg[14:0], 1'b0};
            end
        end
    end

    // write lands on the 24th rising edge unless a read bit is pending
    assign wrEn   = !selS_reg[1] && spiState_reg == SPI_DATA && sRise
                    && bitCnt_reg == 5'(SPI_TOTAL - 1) && !writeBlock_reg;
    assign wrAddr = shiftIn_reg[21:15];
    assign wrData = {shiftIn_reg[14:0], sdiS_reg[1]};

    logic readActive;
    assign readActive       = spiState_reg == SPI_DATA && rw_reg;
    assign serDataOe        = readActive && !wire4;
    assign serDataOut       = shiftOut_reg[15];
    assign serialOutputLine = wire4 ? shiftOut_reg[15] : 1'b0;

    // ****************************************************************
    // sync, output clock and marker
    // ****************************************************************
    logic                  syncSmp_reg, pendMark_reg, outClk_reg, marker_reg, decPhase_reg;
    logic [SYNC_CNT_W-1:0] syncCnt_reg, markPos_reg, syncCntNext;
    logic                  syncEdge, acceptSync, outClkNext, outSample;

    assign syncEdge    = sTick && syncS_reg[1] && !syncSmp_reg;
    assign acceptSync  = syncEdge && (!running_reg || syncCnt_reg != '0);
    assign syncCntNext = acceptSync ? SYNC_CNT_W'(1) : syncCnt_reg + 1'b1;
    // a sync on the high phase holds the clock high one extra half
    assign outClkNext  = (acceptSync && outClk_reg) ? 1'b1 : !outClk_reg;
    assign outSample   = sTick && (!decimEn || decPhase_reg);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            syncSmp_reg    <= 1'b0;
            running_reg    <= 1'b0;
            syncCnt_reg    <= '0;
            markPos_reg    <= '0;
            pendMark_reg   <= 1'b0;
            outClk_reg     <= 1'b0;
            marker_reg     <= 1'b0;
            decPhase_reg   <= 1'b0;
            invalidCnt_reg <= '0;
        end else if (sTick) begin
            syncSmp_reg  <= syncS_reg[1];
            outClk_reg   <= outClkNext;
            decPhase_reg <= acceptSync ? 1'b0 : !decPhase_reg;
            if (acceptSync) begin
                running_reg    <= 1'b1;
                invalidCnt_reg <= decimEn ? INVALID_DECIM : INVALID_FULL;
            end else if (outSample && invalidCnt_reg != '0) begin
                invalidCnt_reg <= invalidCnt_reg - 1'b1;
            end
            if (running_reg || acceptSync) begin
                syncCnt_reg <= syncCntNext;
            end
            if ((acceptSync || pendMark_reg) && outClkNext && !outClk_reg) begin
                marker_reg   <= 1'b1;
                markPos_reg  <= syncCntNext;
                pendMark_reg <= 1'b0;
            end else begin
                pendMark_reg <= pendMark_reg || acceptSync;
                marker_reg   <= running_reg && !pendMark_reg && !acceptSync
                                && syncCntNext == markPos_reg;
            end
        end
    end

    assign channelAOutputClock = outClk_reg;
    assign channelBOutputClock = outClk_reg;
    assign alignMarkerOut      = marker_reg;

    // ****************************************************************
    // data path: correction, over-range, filter
    // ****************************************************************
    logic signed [SMP_W-1:0] raw [2];
    logic signed [ACC_W-1:0] acc_reg [2];
    logic signed [SMP_W-1:0] prev_reg [2];
    // bit 0 is loaded at the sample's own tick, so one extra stage gives 12
    logic [OVR_LATENCY:0]    ovrPipe_reg [2];
    logic signed [SMP_W-1:0] corr [2];
    logic signed [SMP_W-1:0] filt [2];

    assign raw[0] = smpA2_reg;
    assign raw[1] = smpB2_reg;

    function automatic logic ovrHit(input logic signed [SMP_W-1:0] x,
                                    input logic [THR_W-1:0] t);
        logic [SMP_W:0] mag;
        mag = x[SMP_W-1] ? (SMP_W+1)'(-x) : (SMP_W+1)'(x);
        return mag > ((SMP_W+1)'(t) << THR_SCALE_SH);
    endfunction

    function automatic logic signed [SMP_W-1:0] filter(
        input logic signed [SMP_W-1:0] x, input logic signed [SMP_W-1:0] p,
        input logic hp, input logic en);
        logic signed [SMP_W:0] s;
        s = hp ? ((SMP_W+1)'(x) - (SMP_W+1)'(p)) : ((SMP_W+1)'(x) + (SMP_W+1)'(p));
        return en ? s[SMP_W:1] : x;
    endfunction

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            corr[c] = raw[c] - (corrEn[c] ? acc_reg[c][ACC_W-1 -: SMP_W] : '0);
            filt[c] = filter(corr[c], prev_reg[c], highPass[c], decimEn);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int c = 0; c < 2; c++) begin
                acc_reg[c]     <= '0;
                prev_reg[c]    <= '0;
                ovrPipe_reg[c] <= '0;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (restart_reg[c]) begin
                    acc_reg[c] <= '0;
                end else if (sTick && corrEn[c]) begin
                    acc_reg[c] <= acc_reg[c] + ACC_W'(raw[c])
                                  - (acc_reg[c] >>> ACC_SHIFT);
                end
                if (sTick) begin
                    prev_reg[c]    <= acceptSync ? '0 : corr[c];
                    ovrPipe_reg[c] <= acceptSync ? '0 :
                        {ovrPipe_reg[c][OVR_LATENCY-1:0], ovrHit(raw[c], thr_reg)};
                end
            end
        end
    end

    assign overRangeFlagOut = {ovrPipe_reg[1][OVR_LATENCY], ovrPipe_reg[0][OVR_LATENCY]};

    // ****************************************************************
    // output buffer
    // ****************************************************************
    adc_word_t word_reg;
    logic      wordValid_reg;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            word_reg      <= '0;
            wordValid_reg <= 1'b0;
        end else begin
            wordValid_reg <= outSample && running_reg;
            if (outSample) begin
                word_reg.marker    <= marker_reg;
                word_reg.valid     <= invalidCnt_reg == '0;
                word_reg.overRange <= overRangeFlagOut;
                word_reg.dataA     <= {filt[0][SMP_W-1] ^ offsetBin, filt[0][SMP_W-2:0]};
                word_reg.dataB     <= {filt[1][SMP_W-1] ^ offsetBin, filt[1][SMP_W-2:0]};
            end
        end
    end

    // a full buffer drops words; pathReady tells the receiver it stalled too long
    adc_fifo #(
        .W     ($bits(adc_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .inValid  (wordValid_reg),
        .inReady  (pathReady),
        .inData   (word_reg),
        .outValid (outValid),
        .outReady (outReady),
        .outData  (outData)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_THR_RESET: assert property (@(posedge clk_sys)
        $rose(rstn) |-> thr_reg == THR_RST) else $error("threshold not at reset value");
    AST_CORR_OFF: assert property (@(posedge clk_sys) disable iff (!rstn)
        !corrEn[0] && !restart_reg[0] |=> $stable(acc_reg[0]))
        else $error("correction moved while disabled");
    AST_OVR_LEVEL: assert property (@(posedge clk_sys) disable iff (!rstn)
        sTick && !acceptSync && !raw[0][SMP_W-1]
        && ({1'b0, raw[0]} <= ((SMP_W+1)'(thr_reg) << THR_SCALE_SH))
        |=> !ovrPipe_reg[0][0]) else $error("over-range raised below level");
    AST_OVR_LAT: assert property (@(posedge clk_sys) disable iff (!rstn)
        sTick && !acceptSync && ovrPipe_reg[0][OVR_LATENCY-1] |=> overRangeFlagOut[0])
        else $error("over-range flag late");
    AST_INVALID: assert property (@(posedge clk_sys) disable iff (!rstn)
        acceptSync && !decimEn |=> invalidCnt_reg == INVALID_FULL && running_reg)
        else $error("invalid window not 36");
    AST_DEC_INVALID: assert property (@(posedge clk_sys) disable iff (!rstn)
        acceptSync && decimEn |=> invalidCnt_reg == INVALID_DECIM)
        else $error("decimated invalid window not 18");
    AST_SAME_POS: assert property (@(posedge clk_sys) disable iff (!rstn)
        syncEdge && running_reg && syncCnt_reg == '0 |=> syncCnt_reg == SYNC_CNT_W'(1)
        && !pendMark_reg) else $error("aligned sync restarted counter");
    AST_WRITE_BLOCK: assert property (@(posedge clk_sys) disable iff (!rstn)
        writeBlock_reg |=> $stable(cfg_reg) && $stable(thr_reg) && $stable(corr_reg))
        else $error("write accepted while read bit set");
    AST_RW_CAPTURE: assert property (@(posedge clk_sys) disable iff (!rstn)
        !selS_reg[1] && !selFall && spiState_reg == SPI_ADDR && sRise && bitCnt_reg == '0
        |=> rw_reg == $past(sdiS_reg[1])) else $error("read/write bit not captured");
    AST_THREE_WIRE: assert property (@(posedge clk_sys) disable iff (!rstn)
        !wire4 |-> !serialOutputLine && (serDataOe == readActive))
        else $error("three-wire mode drove the output line");
endmodule

// >>> test/adc_spi_ctrl.sv
`timescale 1ns/1ps
// ****************************************************************
// serial controller model
// ****************************************************************
module adc_spi_ctrl (
    // clock
    input  wire logic clk_sys,
    // device side of the data pins
    input  wire logic devBit,
    input  wire logic devOe,
    input  wire logic outLine,
    // controller drive
    output logic      serialClk,
    output logic      serialSelectN,
    output logic      dataLine
);
    logic drv;
    logic bitv;
    initial begin
        serialClk = 0;
        serialSelectN = 1;
        drv = 0;
        bitv = 0;
    end
    // released line flips, so a stale bit never reads as good
    assign dataLine = devOe ? devBit : (drv ? bitv : ~bitv);
    task automatic xfer(input logic [23:0] w, input logic w4, output logic [15:0] q);
        q = 16'h0000;
        serialSelectN <= 1'b0;
        repeat (8) @(posedge clk_sys);
        for (int i = 23; i >= 0; i--) begin
            serialClk <= 1'b0;
            drv <= !(w[23] && i < 16);
            bitv <= w[i];
            repeat (8) @(posedge clk_sys);
            serialClk <= 1'b1;
            if (i < 16) q[i] = w4 ? outLine : dataLine;
            repeat (8) @(posedge clk_sys);
        end
        serialClk <= 1'b0;
        repeat (8) @(posedge clk_sys);
        serialSelectN <= 1'b1;
        drv <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask
endmodule

// >>> test/adc_ctrl_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module adc_ctrl_top_tb;
    import adc_pkg::*;
    logic clk_sys = 0, rstn = 0, sampleClockIn = 0, alignInputPin = 0, outReady = 0;
    logic serialClk, serialSelectN, serDataIn, serDataOut, serDataOe, serialOutputLine;
    logic [SMP_W-1:0] sampleA = '0, sampleB = '0;
    logic channelAOutputClock, channelBOutputClock, alignMarkerOut, pathReady, outValid;
    logic [1:0] overRangeFlagOut;
    adc_word_t outData;
    int bad_count = 0, n_tests = 0, ph = 0, words = 0, t, base = 0, lim = 36, lastMk = -1;
    logic [15:0] q;
    logic [3:0] fld;
    always #4 clk_sys = ~clk_sys;
    adc_ctrl_top adc_ctrl_top_inst (.clk_sys, .rstn, .serialClk, .serialSelectN, .serDataIn,
        .serDataOut, .serDataOe, .serialOutputLine, .sampleClockIn, .sampleA, .sampleB,
        .alignInputPin, .channelAOutputClock, .channelBOutputClock, .overRangeFlagOut,
        .alignMarkerOut, .pathReady, .outValid, .outReady, .outData);
    adc_spi_ctrl adc_spi_ctrl_inst (.clk_sys, .devBit(serDataOut), .devOe(serDataOe),
        .outLine(serialOutputLine), .serialClk, .serialSelectN, .dataLine(serDataIn));
    // ****************************************************************
    // sample clock, drain side and word check
    // ****************************************************************
    always @(posedge clk_sys) begin
        ph <= (ph == 19) ? 0 : ph + 1;
        sampleClockIn <= (ph == 19) || (ph < 9);
        outReady <= 1'($urandom_range(0, 1));
        if (outValid && outReady) begin
            `CHK("valid", words - base >= lim, outData.valid)
            if (outData.marker && lastMk >= 0) `CHK("mk_gap", 32, words - lastMk)
            if (outData.marker) lastMk <= words;
            words <= words + 1;
        end
    end
    task print_verdict;
        if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task rd(input logic [6:0] a, input logic w4, input logic [15:0] e);
        adc_spi_ctrl_inst.xfer({1'b1, a, 16'h0000}, w4, q);
        `CHK("reg", e, q)
    endtask
    task wr(input logic [6:0] a, input logic [15:0] d);
        adc_spi_ctrl_inst.xfer({1'b0, a, d}, 1'b0, q);
    endtask
    task ticks(input int n);
        repeat (n * 20) @(posedge clk_sys);
    endtask
    task mark_rise(output int c);
        c = 0;
        while (alignMarkerOut === 1'b1 && c < 2000) begin @(posedge clk_sys); c++; end
        while (alignMarkerOut !== 1'b1 && c < 2000) begin @(posedge clk_sys); c++; end
        if (c >= 2000) begin bad_count++; print_verdict; end
        `CHK("oclk", 1'b1, channelAOutputClock)
        `CHK("oclkb", 1'b1, channelBOutputClock)
    endtask
    task sync_chk;
        while (ph != 10) @(posedge clk_sys);
        alignInputPin <= 1'b1;
        ticks(1);
        alignInputPin <= 1'b0;
        mark_rise(t);
        mark_rise(t);
        `CHK("period", 640, t)
    endtask
    initial begin
        void'($urandom(38));
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (16) @(posedge clk_sys);
        rd(ADDR_THR, 1'b0, 16'h0780);
        rd(ADDR_CORR, 1'b0, 16'h0000);
        rd(ADDR_RSTA, 1'b0, RST_FIXED);
        rd(ADDR_RSTB, 1'b0, RST_FIXED);
        rd(7'h55, 1'b0, 16'h0000);
        wr(ADDR_CORR, 16'h8208);
        rd(ADDR_CORR, 1'b0, 16'h8208);
        wr(ADDR_RSTB, RST_FIXED | 16'h4000);
        rd(ADDR_RSTB, 1'b0, 16'h4B18);
        wr(ADDR_CFG, 16'h8000);
        rd(ADDR_CFG, 1'b1, 16'h8000);
        sync_chk;
        fld = 4'($urandom_range(1, 14));
        wr(ADDR_THR, {5'h00, fld, 7'h00});
        while (ph != 10) @(posedge clk_sys);
        // equal to the level must not trip, one above must
        sampleA <= {1'b0, fld, 7'h00};
        ticks(1);
        sampleA <= {1'b0, fld, 7'h01};
        ticks(1);
        sampleA <= 12'($urandom_range(0, 127));
        sampleB <= 12'($urandom_range(0, 127));
        ticks(11);
        `CHK("ovr_early", 1'b0, overRangeFlagOut[0])
        ticks(1);
        `CHK("ovr", 1'b1, overRangeFlagOut[0])
        // mid-run reset must restore the map, then a decimated restart
        rstn <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (16) @(posedge clk_sys);
        rd(ADDR_THR, 1'b0, 16'h0780);
        rd(ADDR_CFG, 1'b0, 16'h0000);
        base = words;
        lim = 18;
        wr(ADDR_CFG, 16'h4000);
        rd(ADDR_CFG, 1'b0, 16'h4000);
        sync_chk;
        ticks(20);
        `CHK("dwords", 1'b1, words - base > 20)
        print_verdict;
    end
endmodule
